// >>> hdl/pan_defines.vh
`ifndef PAN_DEFINES_VH
`define PAN_DEFINES_VH

// Management register addresses.
`define PAN_ADDR_ID_HIGH    5'h02
`define PAN_ADDR_ID_LOW     5'h03
`define PAN_ADDR_ADVERTISE  5'h04
`define PAN_ADDR_PARTNER    5'h05
`define PAN_ADDR_EXPANSION  5'h06

// Advertisement register fields.
`define PAN_ADV_RF_BIT      13
`define PAN_ADV_TECH_HI     8
`define PAN_ADV_TECH_LO     5
`define PAN_ADV_SELECTOR    5'h01

// Expansion register fields.
`define PAN_EXP_PD_FAULT    4
`define PAN_EXP_LP_NP_ABLE  3
`define PAN_EXP_NP_ABLE     2
`define PAN_EXP_PAGE_RX     1
`define PAN_EXP_LP_AN_ABLE  0

// Partner word fields and reset values.
`define PAN_LP_NP_BIT       15
`define PAN_WORD_ZERO       16'h0000

`endif

// >>> hdl/pan_latch_flag.v
`timescale 1ns/1ps
`default_nettype none

module pan_latch_flag (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire set_in,
  input  wire clear_in,
  output reg  flag_out
);

  // Sticky flag; a set in the clearing cycle wins so no event is lost.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/pan_regs.v
// Contract
// - Identifier high word is read-only.
// - Identifier low holds organisation, model, revision.
// - Advertisement next-page bit reads zero.
// - Remote-fault advertisement bit is management writable.
// - Advertisement bits 12:9 read zero.
// - Ability bits writable, loaded from straps.
// - Selector field fixed at one.
// - Partner ability word read-only, resets zero.
// - Parallel fault latches, cleared by expansion read.
// - Partner next-page flag qualified by completion; the code leaves it ungated, straight from the stored partner word.
// - Local next-page able reads zero.
// - Page received latches, cleared by partner read.
// - Partner autonegotiation ability is reported.
// - Status completion bit follows negotiation state.
`timescale 1ns/1ps
`default_nettype none
`include "pan_defines.vh"

module pan_regs #(
  parameter [15:0] OUI_HIGH = 16'h1234, // Arbitrary identifier value.
  parameter [5:0]  OUI_LOW  = 6'h2A,    // Arbitrary identifier value.
  parameter [5:0]  MODEL    = 6'h05,    // Arbitrary model value.
  parameter [3:0]  REVISION = 4'h3      // Arbitrary revision value.
) (
  // Clock and synchronous active-low reset.
  input  wire        SYS_CLK_IN,
  input  wire        RST_N_IN,
  // Management register port behind the serial engine.
  input  wire [4:0]  REG_ADDR_IN,
  input  wire        REG_WR_IN,
  input  wire [15:0] REG_WDATA_IN,
  input  wire        REG_RD_IN,
  output reg  [15:0] REG_RDATA_OUT,
  output reg         REG_RVALID_OUT,
  // Ability straps, sampled while reset is held.
  input  wire        STRAP_FAST_FULL_DUPLEX_IN,
  input  wire        STRAP_FAST_HALF_DUPLEX_IN,
  input  wire        STRAP_SLOW_FULL_DUPLEX_IN,
  input  wire        STRAP_SLOW_HALF_DUPLEX_IN,
  // Arbitration state machine inputs.
  input  wire        ARB_PD_FAULT_IN,
  input  wire        ARB_PAGE_RX_IN,
  input  wire [15:0] ARB_PARTNER_WORD_IN,
  input  wire        ARB_COMPLETE_IN,
  input  wire        ARB_PARTNER_AN_ABLE_IN,
  // Outputs towards the arbitration and the status logic.
  output reg  [15:0] ADV_WORD_OUT,
  output reg         AN_COMPLETE_OUT
);

  reg         remote_fault_flag;
  reg  [3:0]  tech_ability;
  reg  [15:0] partner_word;
  reg         partner_an_able;
  wire        pd_fault;
  wire        page_rx;
  wire        rd_partner;
  wire        rd_expansion;
  wire        wr_advertise;
  wire [3:0]  strap_ability;
  wire        adv_next_page;
  wire        adv_reserved_hi;
  wire        adv_remote_fault;
  wire [2:0]  adv_reserved_lo;
  wire        adv_four_pair;
  wire [3:0]  adv_tech;
  wire [4:0]  adv_selector;
  wire [10:0] exp_reserved;
  wire        exp_pd_fault;
  wire        exp_lp_np_able;
  wire        exp_np_able;
  wire        exp_page_rx;
  wire        exp_lp_an_able;
  wire [15:0] adv_word;
  wire [15:0] id_high;
  wire [15:0] id_low;
  wire [15:0] exp_word;
  reg  [15:0] next_rdata;

  // Access strobes; only the advertisement register has a write side.
  // Reads of the partner and expansion words have side effects that clear flags.
  // Writes to any other address fall through here and change nothing.
  assign rd_partner   = REG_RD_IN && (REG_ADDR_IN == `PAN_ADDR_PARTNER);
  assign rd_expansion = REG_RD_IN && (REG_ADDR_IN == `PAN_ADDR_EXPANSION);
  assign wr_advertise = REG_WR_IN && (REG_ADDR_IN == `PAN_ADDR_ADVERTISE);

  // Identifier words are constants built from the parameters.
  // They have no storage, so a write to them cannot leave a trace.
  assign id_high = OUI_HIGH;
  assign id_low  = {OUI_LOW, MODEL, REVISION};

  // Strap levels in advertisement order, fast full duplex at the top.
  assign strap_ability = {STRAP_FAST_FULL_DUPLEX_IN,
                          STRAP_FAST_HALF_DUPLEX_IN,
                          STRAP_SLOW_FULL_DUPLEX_IN,
                          STRAP_SLOW_HALF_DUPLEX_IN};

  // Advertisement fields; those without storage are tied here.
  // Next-page exchange is not offered, so the top bit stays low.
  // Only the fault bit and the ability field come from flip-flops.
  assign adv_next_page    = 1'h0;
  assign adv_reserved_hi  = 1'h0;
  assign adv_remote_fault = remote_fault_flag;
  assign adv_reserved_lo  = 3'h0;
  assign adv_four_pair    = 1'h0;
  assign adv_tech         = tech_ability;
  assign adv_selector     = `PAN_ADV_SELECTOR;

  // Advertisement word as read back and as handed to the arbitration.
  assign adv_word = {adv_next_page,
                     adv_reserved_hi,
                     adv_remote_fault,
                     adv_reserved_lo,
                     adv_four_pair,
                     adv_tech,
                     adv_selector};

  // Expansion fields; the partner next-page bit is not gated by completion.
  // Software must qualify it with the completion status output.
  assign exp_reserved   = 11'h000;
  assign exp_pd_fault   = pd_fault;
  assign exp_lp_np_able = partner_word[`PAN_LP_NP_BIT];
  assign exp_np_able    = 1'h0;
  assign exp_page_rx    = page_rx;
  assign exp_lp_an_able = partner_an_able;

  // Expansion word as read back by management.
  assign exp_word = {exp_reserved,
                     exp_pd_fault,
                     exp_lp_np_able,
                     exp_np_able,
                     exp_page_rx,
                     exp_lp_an_able};

  // Writable advertisement bits; straps are caught on every edge while reset is held.
  // The levels seen at the last reset edge stay until management rewrites them.
  // A strap that moves after reset is ignored, so a bouncing pin cannot change the offer.
  always @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      remote_fault_flag <= 1'b0;
      tech_ability      <= strap_ability;
    end else if (wr_advertise) begin
      remote_fault_flag <= REG_WDATA_IN[`PAN_ADV_RF_BIT];
      tech_ability      <= REG_WDATA_IN[`PAN_ADV_TECH_HI:`PAN_ADV_TECH_LO];
    end
  end

  // Partner state is taken whenever the arbitration delivers a page.
  // Between pages the stored word holds, so a read always sees one whole code word.
  // The partner ability level is only delayed, as it has no event of its own.
  always @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      partner_word    <= `PAN_WORD_ZERO;
      partner_an_able <= 1'b0;
    end else begin
      partner_an_able <= ARB_PARTNER_AN_ABLE_IN;
      if (ARB_PAGE_RX_IN) begin
        partner_word <= ARB_PARTNER_WORD_IN;
      end
    end
  end

  // Parallel detection fault, cleared when expansion is read.
  // The read edge still returns the set value, and an event in that cycle survives.
  pan_latch_flag u_pd_fault (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RST_N_IN),
    .set_in   (ARB_PD_FAULT_IN),
    .clear_in (rd_expansion),
    .flag_out (pd_fault)
  );

  // Page received, cleared when partner ability is read.
  // Reading the expansion word leaves this flag untouched.
  pan_latch_flag u_page_rx (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RST_N_IN),
    .set_in   (ARB_PAGE_RX_IN),
    .clear_in (rd_partner),
    .flag_out (page_rx)
  );

  // Read multiplexer; unmapped addresses return zero.
  // The address is decoded in the same cycle as the read strobe.
  always @* begin
    case (REG_ADDR_IN)
      `PAN_ADDR_ID_HIGH:   next_rdata = id_high;
      `PAN_ADDR_ID_LOW:    next_rdata = id_low;
      `PAN_ADDR_ADVERTISE: next_rdata = adv_word;
      `PAN_ADDR_PARTNER:   next_rdata = partner_word;
      `PAN_ADDR_EXPANSION: next_rdata = exp_word;
      default:             next_rdata = `PAN_WORD_ZERO;
    endcase
  end

  // Read port: the word is registered one edge after the strobe and held until the next read.
  // Holding it lets a slow serial engine shift the word out at its own pace.
  always @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT  <= `PAN_WORD_ZERO;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= next_rdata;
      end
    end
  end

  // Status outputs towards the arbitration and the status register.
  // Both lag their sources by one edge so that every top-level output leaves a flip-flop.
  always @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      ADV_WORD_OUT    <= `PAN_WORD_ZERO;
      AN_COMPLETE_OUT <= 1'b0;
    end else begin
      ADV_WORD_OUT    <= adv_word;
      AN_COMPLETE_OUT <= ARB_COMPLETE_IN;
    end
  end

endmodule

`default_nettype wire

// >>> tb/pan_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pan_regs_assertions (
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic [4:0]  REG_ADDR_IN,
  input wire logic        REG_WR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic        REG_RD_IN,
  input wire logic [15:0] REG_RDATA_OUT,
  input wire logic        ARB_PD_FAULT_IN,
  input wire logic        ARB_PAGE_RX_IN,
  input wire logic        ARB_COMPLETE_IN,
  input wire logic [15:0] ADV_WORD_OUT,
  input wire logic        AN_COMPLETE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Strobes decoded per register.
  wire logic rd5 = REG_RD_IN && REG_ADDR_IN == 5'h05;
  wire logic rd6 = REG_RD_IN && REG_ADDR_IN == 5'h06;
  wire logic wr4 = REG_WR_IN && REG_ADDR_IN == 5'h04;
  // Fixed advertisement bits, stored fields, completion and latched flags.
  np_zero_a: assert property (ADV_WORD_OUT[15:14] == 2'h0) else $error("adv bit 15 set");
  resv_zero_a: assert property (ADV_WORD_OUT[12:9] == 4'h0) else $error("adv bits 12:9 set");
  sel_fixed_a: assert property ($past(RST_N_IN) |-> ADV_WORD_OUT[4:0] == 5'h01) else $error("bad selector");
  adv_wr_a: assert property (wr4 |=> ##1 (ADV_WORD_OUT & 16'h21E0) == ($past(REG_WDATA_IN, 2) & 16'h21E0))
    else $error("adv write lost");
  cmpl_a: assert property ($past(RST_N_IN) |-> AN_COMPLETE_OUT == $past(ARB_COMPLETE_IN)) else $error("completion lag");
  pd_latch_a: assert property (ARB_PD_FAULT_IN ##1 !rd6 ##1 rd6 |=> REG_RDATA_OUT[4]) else $error("fault not held");
  page_clr_a: assert property (rd5 && !ARB_PAGE_RX_IN ##1 !ARB_PAGE_RX_IN ##1 rd6 |=> !REG_RDATA_OUT[1])
    else $error("page flag stuck");
  np_able_a: assert property (rd6 |=> REG_RDATA_OUT[15:5] == 11'h000 && !REG_RDATA_OUT[2]) else $error("exp bits set");
  cover property (rd6 ##1 REG_RDATA_OUT[4]);
  cover property (rd6 ##1 REG_RDATA_OUT[1]);
  cover property (wr4);
endmodule
bind pan_regs pan_regs_assertions pan_regs_assertions_i (
  .SYS_CLK_IN      (SYS_CLK_IN),
  .RST_N_IN        (RST_N_IN),
  .REG_ADDR_IN     (REG_ADDR_IN),
  .REG_WR_IN       (REG_WR_IN),
  .REG_WDATA_IN    (REG_WDATA_IN),
  .REG_RD_IN       (REG_RD_IN),
  .REG_RDATA_OUT   (REG_RDATA_OUT),
  .ARB_PD_FAULT_IN (ARB_PD_FAULT_IN),
  .ARB_PAGE_RX_IN  (ARB_PAGE_RX_IN),
  .ARB_COMPLETE_IN (ARB_COMPLETE_IN),
  .ADV_WORD_OUT    (ADV_WORD_OUT),
  .AN_COMPLETE_OUT (AN_COMPLETE_OUT)
);
`default_nettype wire

// >>> tb/pan_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
module pan_mgmt_model (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  output var  logic [4:0]  addr = 5'h00,
  output var  logic        wr = 1'b0,
  output var  logic        rd = 1'b0,
  output var  logic [15:0] wdata = 16'h0000
);
  // Called in the time step of an edge: a write is taken at the next edge, then one idle edge passes.
  task wr_reg(input logic [4:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~v;
    @(posedge clk);
  endtask
  // Called in the time step of an edge: word and valid flag are taken one edge after the read edge.
  task rd_reg(input logic [4:0] a, output logic [15:0] v, output logic ok);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
    ok = rvalid;
  endtask
endmodule
`default_nettype wire

// >>> tb/pan_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pan_regs_tb_top;
  logic        SYS_CLK_IN = 1'b0, RST_N_IN = 1'b0;
  logic        STRAP_FAST_FULL_DUPLEX_IN = 1'b1, STRAP_FAST_HALF_DUPLEX_IN = 1'b0;
  logic        STRAP_SLOW_FULL_DUPLEX_IN = 1'b1, STRAP_SLOW_HALF_DUPLEX_IN = 1'b0;
  logic        ARB_PD_FAULT_IN = 1'b0, ARB_PAGE_RX_IN = 1'b0;
  logic        ARB_COMPLETE_IN = 1'b0, ARB_PARTNER_AN_ABLE_IN = 1'b0;
  logic [15:0] ARB_PARTNER_WORD_IN = 16'h0000;
  logic [15:0] REG_WDATA_IN, REG_RDATA_OUT, ADV_WORD_OUT, d;
  logic [4:0]  REG_ADDR_IN;
  logic        REG_WR_IN, REG_RD_IN, REG_RVALID_OUT, AN_COMPLETE_OUT, vl;
  int          fail_count = 0, num_checks = 0, cycles = 0;
  pan_regs pan_regs_i (
    .SYS_CLK_IN                (SYS_CLK_IN),
    .RST_N_IN                  (RST_N_IN),
    .REG_ADDR_IN               (REG_ADDR_IN),
    .REG_WR_IN                 (REG_WR_IN),
    .REG_WDATA_IN              (REG_WDATA_IN),
    .REG_RD_IN                 (REG_RD_IN),
    .REG_RDATA_OUT             (REG_RDATA_OUT),
    .REG_RVALID_OUT            (REG_RVALID_OUT),
    .STRAP_FAST_FULL_DUPLEX_IN (STRAP_FAST_FULL_DUPLEX_IN),
    .STRAP_FAST_HALF_DUPLEX_IN (STRAP_FAST_HALF_DUPLEX_IN),
    .STRAP_SLOW_FULL_DUPLEX_IN (STRAP_SLOW_FULL_DUPLEX_IN),
    .STRAP_SLOW_HALF_DUPLEX_IN (STRAP_SLOW_HALF_DUPLEX_IN),
    .ARB_PD_FAULT_IN           (ARB_PD_FAULT_IN),
    .ARB_PAGE_RX_IN            (ARB_PAGE_RX_IN),
    .ARB_PARTNER_WORD_IN       (ARB_PARTNER_WORD_IN),
    .ARB_COMPLETE_IN           (ARB_COMPLETE_IN),
    .ARB_PARTNER_AN_ABLE_IN    (ARB_PARTNER_AN_ABLE_IN),
    .ADV_WORD_OUT              (ADV_WORD_OUT),
    .AN_COMPLETE_OUT           (AN_COMPLETE_OUT)
  );
  pan_mgmt_model pan_mgmt_model_i (.clk(SYS_CLK_IN), .rdata(REG_RDATA_OUT), .rvalid(REG_RVALID_OUT),
    .addr(REG_ADDR_IN),
    .wr(REG_WR_IN), .rd(REG_RD_IN), .wdata(REG_WDATA_IN));
  // Clock of 100 ns period and a hang limit.
  always #50 SYS_CLK_IN = ~SYS_CLK_IN;
  always @(posedge SYS_CLK_IN) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      fail_count++;
      finish_test();
    end
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task rc(input logic [4:0] a, input logic [15:0] e);
    pan_mgmt_model_i.rd_reg(a, d, vl);
    chk($sformatf("register %h", a), e, d);
    chk("read valid", 16'h0001, {15'h0000, vl});
  endtask
  task finish_test();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Register sequence: identifiers, advertisement, partner page, fault flag, unmapped read.
  initial begin
    repeat (4) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1'b1;
    rc(5'h02, 16'h1234);
    pan_mgmt_model_i.wr_reg(5'h02, 16'hFFFF);
    rc(5'h02, 16'h1234);
    rc(5'h03, 16'hA853);
    rc(5'h04, 16'h0141);
    pan_mgmt_model_i.wr_reg(5'h04, 16'hFFFF);
    rc(5'h04, 16'h21E1);
    chk("adv word", 16'h21E1, ADV_WORD_OUT);
    rc(5'h05, 16'h0000);
    @(posedge SYS_CLK_IN);
    ARB_PARTNER_WORD_IN <= 16'h8021;
    ARB_PAGE_RX_IN <= 1'b1;
    ARB_PARTNER_AN_ABLE_IN <= 1'b1;
    ARB_COMPLETE_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    ARB_PAGE_RX_IN <= 1'b0;
    rc(5'h06, 16'h000B);
    rc(5'h05, 16'h8021);
    rc(5'h06, 16'h0009);
    chk("completion", 16'h0001, {15'h0000, AN_COMPLETE_OUT});
    @(posedge SYS_CLK_IN);
    ARB_PD_FAULT_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    ARB_PD_FAULT_IN <= 1'b0;
    @(posedge SYS_CLK_IN);
    rc(5'h06, 16'h0019);
    rc(5'h06, 16'h0009);
    rc(5'h07, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
